// [core/cswe_consts.svh]
// Purpose: offsets, field positions and reset values for the socket status/window block
// Assumes: memory offsets are socket-relative bytes, legacy indices are 8-bit
// Notes: definitions only
`ifndef CSWE_CONSTS_SVH
`define CSWE_CONSTS_SVH
// ********************************************************
// register offsets, memory map (socket base relative)
// ********************************************************
`define CSWE_OFS_FLAGS 12'h804
`define CSWE_OFS_IRQCFG 12'h805
`define CSWE_OFS_WINEN 12'h806
`define CSWE_OFS_IOCTL 12'h807
// ********************************************************
// legacy indexed map
// ********************************************************
`define CSWE_IDX_A_FLAGS 8'h04
`define CSWE_IDX_A_IRQCFG 8'h05
`define CSWE_IDX_A_WINEN 8'h06
`define CSWE_IDX_A_IOCTL 8'h07
`define CSWE_IDX_B_FLAGS 8'h44
`define CSWE_IDX_B_IRQCFG 8'h45
`define CSWE_IDX_B_WINEN 8'h46
`define CSWE_IDX_B_IOCTL 8'h47
// ********************************************************
// reset values and fields
// ********************************************************
`define CSWE_RST_BYTE 8'h00
`define CSWE_WINEN_WMASK 8'hdf
`define CSWE_WIN_RESERVED_BIT_POS 5
`define CSWE_ROUTE_NONE 4'h0
`define CSWE_ROUTE_SMI 4'h2
`define CSWE_FLAG_CD 3
`define CSWE_FLAG_RDY 2
`define CSWE_FLAG_BWARN 1
`define CSWE_FLAG_BDEAD 0
`endif

// [core/cswe_pkg.sv]
// Purpose: shared types for the socket status/window block
// Assumes: constants come from cswe_consts.svh
// Notes: types only
package cswe_pkg;
  // ********************************************************
  // card pins as seen at the socket
  // ********************************************************
  typedef struct packed {
    logic [1:0] detect; // both card-detect lines
    logic ready; // card ready line
    logic batt_warn; // battery warning, memory card
    logic batt_dead; // battery dead, or status change for i/o card
  } cswe_card_s;
  // interrupt configuration byte layout
  typedef struct packed {
    logic [3:0] route; // status_change_route_select
    logic cd_en; // card_detect_irq_enable
    logic rdy_en; // ready_rise_irq_enable
    logic bwarn_en; // battery_warning_irq_enable
    logic bdead_en; // battery_dead_irq_enable
  } cswe_irqcfg_s;
  // window enable byte layout
  typedef struct packed {
    logic io_window_one_on;
    logic io_window_zero_on;
    logic reserved_bit;
    logic [4:0] memory_window_on; // windows 4 down to 0
  } cswe_winen_s;
  // register selected by an access
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_FLAGS,
    SEL_IRQCFG,
    SEL_WINEN,
    SEL_IOCTL
  } cswe_sel_e;
endpackage : cswe_pkg

// [core/cswe_top.sv]
// Purpose: per-socket status-change interrupt config, flags and window enables
// Assumes: one clock, register port driven by the host-side decoder on the same clock
// Notes: card pins pass a three-stage synchroniser before use
`include "cswe_consts.svh"

//
// Contract
// - code 0000 and diag set: PCI always
// - code 0000, diag clear: PCI only if socket bit
// - route field picks PCI or none, SMI or IRQ
// - card-detect change interrupts when enabled
// - ready rising edge interrupts when enabled, memory card only; ignored for an i/o card
// - battery warning interrupts when enabled, memory card only; ignored for an i/o card
// - battery dead or status change interrupts
// - disabled window never claims a cycle
// - window enables reset to zero
// - bits 7,6 enable i/o windows 1,0
// - bits 4..0 enable memory windows
// - bit 5 reads zero, ignores writes
// - window enables at 806h, index 06h/46h
// - interrupt config at 805h, index 05h/45h
// - disabled flag reads zero; enabled flag sets
// - flags clear by read or write-one, mode bit
module cswe_top (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic I_REG_LEGACY,
  input wire logic I_SOCKET_B,
  input wire logic [11:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_REG_ACK,
  input wire logic I_DIAG_PCI_ROUTE,
  input wire logic I_SOCK_PCI_ROUTE,
  input wire logic I_FLAG_WRITE_CLEAR,
  input wire logic I_CARD_IS_IO,
  input wire cswe_pkg::cswe_card_s I_CARD,
  input wire logic [4:0] I_MEM_WIN_HIT,
  input wire logic [1:0] I_IO_WIN_HIT,
  output logic O_CLAIM,
  output logic [4:0] O_MEM_WIN_ON,
  output logic [1:0] O_IO_WIN_ON,
  output logic [15:0] O_ISA_IRQ,
  output logic O_SMI,
  output logic O_PCI_INT
);
  // ********************************************************
  // register decode
  // ********************************************************
  // one decoder for reads and writes so both maps stay in step
  function automatic cswe_pkg::cswe_sel_e reg_sel(input logic [11:0] addr, input logic legacy,
                                                  input logic sock_b);
    logic [7:0] idx;
    idx = addr[7:0];
    reg_sel = cswe_pkg::SEL_NONE;
    if (!legacy) begin
      unique case (addr)
        `CSWE_OFS_FLAGS: reg_sel = cswe_pkg::SEL_FLAGS;
        `CSWE_OFS_IRQCFG: reg_sel = cswe_pkg::SEL_IRQCFG;
        `CSWE_OFS_WINEN: reg_sel = cswe_pkg::SEL_WINEN;
        `CSWE_OFS_IOCTL: reg_sel = cswe_pkg::SEL_IOCTL;
        default: reg_sel = cswe_pkg::SEL_NONE;
      endcase
    end else if (addr[11:8] == 4'h0) begin
      // socket input picks the index table; upper index bits must match that socket
      if (!sock_b) begin
        unique case (idx)
          `CSWE_IDX_A_FLAGS: reg_sel = cswe_pkg::SEL_FLAGS;
          `CSWE_IDX_A_IRQCFG: reg_sel = cswe_pkg::SEL_IRQCFG;
          `CSWE_IDX_A_WINEN: reg_sel = cswe_pkg::SEL_WINEN;
          `CSWE_IDX_A_IOCTL: reg_sel = cswe_pkg::SEL_IOCTL;
          default: reg_sel = cswe_pkg::SEL_NONE;
        endcase
      end else begin
        unique case (idx)
          `CSWE_IDX_B_FLAGS: reg_sel = cswe_pkg::SEL_FLAGS;
          `CSWE_IDX_B_IRQCFG: reg_sel = cswe_pkg::SEL_IRQCFG;
          `CSWE_IDX_B_WINEN: reg_sel = cswe_pkg::SEL_WINEN;
          `CSWE_IDX_B_IOCTL: reg_sel = cswe_pkg::SEL_IOCTL;
          default: reg_sel = cswe_pkg::SEL_NONE;
        endcase
      end
    end
  endfunction : reg_sel

  cswe_pkg::cswe_sel_e sel; // register hit by this access
  logic wr_hit_cfg; // write strobes per register
  logic wr_hit_win;
  logic wr_hit_ioc;
  logic wr_hit_flg;
  logic rd_hit_flg; // read of the flag byte

  assign sel = reg_sel(I_REG_ADDR, I_REG_LEGACY, I_SOCKET_B);
  assign wr_hit_cfg = I_REG_WR && (sel == cswe_pkg::SEL_IRQCFG);
  assign wr_hit_win = I_REG_WR && (sel == cswe_pkg::SEL_WINEN);
  assign wr_hit_ioc = I_REG_WR && (sel == cswe_pkg::SEL_IOCTL);
  assign wr_hit_flg = I_REG_WR && (sel == cswe_pkg::SEL_FLAGS);
  assign rd_hit_flg = I_REG_RD && (sel == cswe_pkg::SEL_FLAGS);

  // ********************************************************
  // control registers
  // ********************************************************
  cswe_pkg::cswe_irqcfg_s irqcfg_r; // status-change interrupt config
  cswe_pkg::cswe_winen_s winen_r; // window enables
  logic [7:0] ioctl_r; // i/o window timing, stored only

  // interrupt config, plain read/write
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      irqcfg_r <= `CSWE_RST_BYTE;
    end else if (wr_hit_cfg) begin
      irqcfg_r <= I_REG_WDATA;
    end
  end

  // window enables; reserved bit masked on write so it stays zero
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      winen_r <= `CSWE_RST_BYTE;
    end else if (wr_hit_win) begin
      winen_r <= I_REG_WDATA & `CSWE_WINEN_WMASK;
    end
  end

  // i/o timing byte, stored and read back only; no port drives it out
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ioctl_r <= `CSWE_RST_BYTE;
    end else if (wr_hit_ioc) begin
      ioctl_r <= I_REG_WDATA;
    end
  end

  // ********************************************************
  // card pin synchroniser
  // ********************************************************
  // three stages; filtered value moves only when stages two and three agree
  localparam int CW = $bits(cswe_pkg::cswe_card_s);
  logic [CW-1:0] sync1_r; // metastable stage, read by sync2_r only
  logic [CW-1:0] sync2_r;
  logic [CW-1:0] sync3_r;
  cswe_pkg::cswe_card_s card_r; // accepted pin levels
  cswe_pkg::cswe_card_s card_prev_r; // levels one cycle earlier

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= I_CARD;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // per-bit agreement filter
  genvar gi;
  generate
    for (gi = 0; gi < CW; gi++) begin : g_filt
      always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
          card_r[gi] <= 1'b0;
        end else if (sync2_r[gi] == sync3_r[gi]) begin
          card_r[gi] <= sync3_r[gi];
        end
      end
    end
  endgenerate

  // history for edge detection
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      card_prev_r <= '0;
    end else begin
      card_prev_r <= card_r;
    end
  end

  // ********************************************************
  // status-change events
  // ********************************************************
  logic [3:0] evt; // raw events, before enables
  logic [3:0] en_mask; // per-source enables
  logic [3:0] flags_r; // sticky status-change flags
  logic [3:0] flags_nxt;
  logic [3:0] flag_clr; // clear request this cycle

  always_comb begin
    evt = 4'h0;
    evt[`CSWE_FLAG_CD] = card_r.detect != card_prev_r.detect;
    // ready and battery warning only mean something for memory cards
    evt[`CSWE_FLAG_RDY] = !I_CARD_IS_IO && card_r.ready && !card_prev_r.ready;
    evt[`CSWE_FLAG_BWARN] = !I_CARD_IS_IO && card_r.batt_warn;
    evt[`CSWE_FLAG_BDEAD] = card_r.batt_dead;
  end

  assign en_mask = {irqcfg_r.cd_en, irqcfg_r.rdy_en, irqcfg_r.bwarn_en, irqcfg_r.bdead_en};

  // clear method chosen by the global mode input
  always_comb begin
    if (I_FLAG_WRITE_CLEAR) begin
      flag_clr = wr_hit_flg ? I_REG_WDATA[3:0] : 4'h0;
    end else begin
      flag_clr = rd_hit_flg ? 4'hf : 4'h0;
    end
  end

  // set wins over clear so an event in the clearing cycle is kept
  always_comb begin
    flags_nxt = ((flags_r & ~flag_clr) | (evt & en_mask)) & en_mask;
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ********************************************************
  // interrupt routing
  // ********************************************************
  logic pending; // any enabled flag still set
  logic [15:0] isa_nxt;
  logic smi_nxt;
  logic pci_nxt;

  assign pending = |(flags_r & en_mask);

  always_comb begin
    isa_nxt = 16'h0000;
    smi_nxt = 1'b0;
    pci_nxt = 1'b0;
    if (irqcfg_r.route == `CSWE_ROUTE_NONE) begin
      // diag bit overrides the socket routing bit
      pci_nxt = pending && (I_DIAG_PCI_ROUTE || I_SOCK_PCI_ROUTE);
    end else if (irqcfg_r.route == `CSWE_ROUTE_SMI) begin
      smi_nxt = pending;
    end else begin
      isa_nxt[irqcfg_r.route] = pending;
    end
  end

  // registered so the pins never glitch on a route change
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_ISA_IRQ <= 16'h0000;
      O_SMI <= 1'b0;
      O_PCI_INT <= 1'b0;
    end else begin
      O_ISA_IRQ <= isa_nxt;
      O_SMI <= smi_nxt;
      O_PCI_INT <= pci_nxt;
    end
  end

  // ********************************************************
  // window gating
  // ********************************************************
  // address comparators live outside; the enable has the last word
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_CLAIM <= 1'b0;
      O_MEM_WIN_ON <= 5'h00;
      O_IO_WIN_ON <= 2'h0;
    end else begin
      O_CLAIM <= |(I_MEM_WIN_HIT & winen_r.memory_window_on) |
                 |(I_IO_WIN_HIT & {winen_r.io_window_one_on, winen_r.io_window_zero_on});
      O_MEM_WIN_ON <= winen_r.memory_window_on;
      O_IO_WIN_ON <= {winen_r.io_window_one_on, winen_r.io_window_zero_on};
    end
  end

  // ********************************************************
  // read path
  // ********************************************************
  logic [7:0] rdata_nxt;

  // unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (sel)
      cswe_pkg::SEL_FLAGS: rdata_nxt = {4'h0, flags_r & en_mask};
      cswe_pkg::SEL_IRQCFG: rdata_nxt = irqcfg_r;
      cswe_pkg::SEL_WINEN: rdata_nxt = winen_r;
      cswe_pkg::SEL_IOCTL: rdata_nxt = ioctl_r;
      cswe_pkg::SEL_NONE: rdata_nxt = 8'h00;
    endcase
  end

  // one-cycle answer for every read or write
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_REG_RDATA <= 8'h00;
      O_REG_ACK <= 1'b0;
    end else begin
      O_REG_RDATA <= I_REG_RD ? rdata_nxt : 8'h00;
      O_REG_ACK <= I_REG_RD || I_REG_WR;
    end
  end
endmodule : cswe_top

// [sim/cswe_chk.sv]
// Purpose: port checks for the socket status/window block
// Assumes: one clock, reset high
// Notes: bound after endmodule
`include "cswe_consts.svh"
// ****
// checker
// ****
module cswe_chk (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic I_REG_LEGACY,
  input wire logic [11:0] I_REG_ADDR,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic O_REG_ACK,
  input wire logic [4:0] I_MEM_WIN_HIT,
  input wire logic [1:0] I_IO_WIN_HIT,
  input wire logic O_CLAIM,
  input wire logic [4:0] O_MEM_WIN_ON,
  input wire logic [1:0] O_IO_WIN_ON,
  input wire logic [15:0] O_ISA_IRQ,
  input wire logic O_SMI,
  input wire logic O_PCI_INT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // register port answers exactly once, one cycle on
  ack_follows_a: assert property ((I_REG_RD || I_REG_WR) |=> O_REG_ACK) else $error("ack missing");
  ack_quiet_a: assert property (!(I_REG_RD || I_REG_WR) |=> !O_REG_ACK) else $error("stray ack");
  rdata_idle_a: assert property (!I_REG_RD |=> O_REG_RDATA == 8'h00) else $error("rdata not idle");
  // only 804..807h answer with data in the memory map
  unmapped_zero_a: assert property (I_REG_RD && !I_REG_LEGACY && I_REG_ADDR[11:2] != 10'h201
    |=> O_REG_RDATA == 8'h00) else $error("unmapped read not zero");
  reserved_bit_zero_a: assert property (I_REG_RD && !I_REG_LEGACY && I_REG_ADDR == `CSWE_OFS_WINEN
    |=> !O_REG_RDATA[5]) else $error("reserved bit set");
  // a claim needs a hit on a window that was on; the enable copy lags like the claim
  claim_cause_a: assert property (O_CLAIM |-> |($past({I_IO_WIN_HIT, I_MEM_WIN_HIT})
    & {O_IO_WIN_ON, O_MEM_WIN_ON})) else $error("claim on disabled window");
  claim_hit_a: assert property (|($past({I_IO_WIN_HIT, I_MEM_WIN_HIT}) & {O_IO_WIN_ON, O_MEM_WIN_ON})
    |-> O_CLAIM) else $error("enabled hit not claimed");
  irq_onehot_a: assert property ($onehot0(O_ISA_IRQ) && !O_ISA_IRQ[0] && !O_ISA_IRQ[2]) else $error("bad irq");
  route_excl_a: assert property (!(O_SMI && (O_PCI_INT || O_ISA_IRQ != 16'h0000))) else $error("two targets");
  win_reset_a: assert property ($fell(I_RST) |-> {O_IO_WIN_ON, O_MEM_WIN_ON} == 7'h00) else $error("win on");
  wr_c: cover property (I_REG_WR ##1 O_REG_ACK);
  claim_c: cover property (O_CLAIM);
  smi_c: cover property (O_SMI);
  pci_c: cover property (O_PCI_INT);
endmodule : cswe_chk
bind cswe_top cswe_chk u_cswe_chk (.*);

// [sim/cswe_card_mdl.sv]
// Purpose: inserted card driving the socket pins
// Assumes: bench asks for pin levels
// Notes: pins are asynchronous to the block anyway
module cswe_card_mdl (
  input wire logic i_clk,
  input wire cswe_pkg::cswe_card_s i_want,
  output cswe_pkg::cswe_card_s o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins settle one edge after the request, never in the bench's own step
  always_ff @(posedge i_clk) begin
    o_pins <= i_want;
  end
endmodule : cswe_card_mdl

// [sim/test_card_status_irq_and_window_enable.sv]
// Purpose: directed register and card-event tests
// Assumes: 25 MHz clock, reset high for 8 cycles
// Notes: waits of 8 cycles cover the pin synchroniser
`include "cswe_consts.svh"
module test_card_status_irq_and_window_enable;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // stimulus and wires
  // ****
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, leg = 1'b0, sockb = 1'b0;
  logic diag = 1'b0, sockr = 1'b0, wclr = 1'b0, isio = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic [4:0] memhit = 5'h00;
  logic [1:0] iohit = 2'h0;
  cswe_pkg::cswe_card_s want = 5'h00;
  cswe_pkg::cswe_card_s card;
  logic [7:0] rdata;
  logic ack, claim, smi, pci;
  logic [4:0] memon;
  logic [1:0] ioon;
  logic [15:0] isa;
  int n_mismatch = 0, compares = 0, j, s;
  cswe_top u_cswe_top (.I_CLOCK(clk), .I_RST(rst), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_LEGACY(leg),
    .I_SOCKET_B(sockb), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_ACK(ack),
    .I_DIAG_PCI_ROUTE(diag), .I_SOCK_PCI_ROUTE(sockr), .I_FLAG_WRITE_CLEAR(wclr), .I_CARD_IS_IO(isio),
    .I_CARD(card), .I_MEM_WIN_HIT(memhit), .I_IO_WIN_HIT(iohit), .O_CLAIM(claim), .O_MEM_WIN_ON(memon),
    .O_IO_WIN_ON(ioon), .O_ISA_IRQ(isa), .O_SMI(smi), .O_PCI_INT(pci));
  cswe_card_mdl u_cswe_card_mdl (.i_clk(clk), .i_want(want), .o_pins(card));
  initial begin
    forever #20 clk = ~clk;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one strobe cycle, answer checked one cycle later
  task automatic acc(input logic w, input logic l, input logic b, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    leg <= l;
    sockb <= b;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    chk(ack, 1'b1);
  endtask : acc
  task automatic wrm(input logic [11:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, 1'b0, a, d);
  endtask : wrm
  task automatic rdm(input logic [11:0] a, input logic [7:0] e);
    acc(1'b0, 1'b0, 1'b0, a, 8'h00);
    chk(rdata, e);
  endtask : rdm
  // one-cycle comparator hit, claim expected the cycle after
  task automatic hit(input logic [6:0] h, input logic e);
    @(posedge clk);
    memhit <= h[4:0];
    iohit <= h[6:5];
    @(posedge clk);
    memhit <= 5'h00;
    iohit <= 2'h0;
    #1;
    chk(claim, e);
  endtask : hit
  task automatic pins(input logic [4:0] p);
    @(posedge clk);
    want <= p;
    repeat (8) @(posedge clk);
    #1;
  endtask : pins
  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  // ****
  // tests
  // ****
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdm(`CSWE_OFS_WINEN, 8'h00);
    rdm(`CSWE_OFS_IRQCFG, 8'h00);
    chk({ioon, memon}, 7'h00);
    wrm(`CSWE_OFS_WINEN, 8'hff);
    rdm(`CSWE_OFS_WINEN, 8'hdf);
    chk({ioon, memon}, 7'h7f);
    acc(1'b1, 1'b1, 1'b0, 12'h006, 8'h41);
    acc(1'b0, 1'b1, 1'b1, 12'h046, 8'h00);
    chk(rdata, 8'h41);
    acc(1'b1, 1'b1, 1'b1, 12'h045, 8'h50);
    rdm(`CSWE_OFS_IRQCFG, 8'h50);
    rdm(12'h808, 8'h00);
    // timing byte next door must not alias onto the window enables
    wrm(`CSWE_OFS_IOCTL, 8'ha5);
    rdm(`CSWE_OFS_WINEN, 8'h41);
    rdm(`CSWE_OFS_IOCTL, 8'ha5);
    // one window on at a time, every window hit
    for (j = 0; j < 7; j++) begin
      wrm(`CSWE_OFS_WINEN, (j < 5) ? 8'h01 << j : 8'h01 << (j + 1));
      for (s = 0; s < 7; s++) hit(7'h01 << s, j == s);
    end
    // every route code, then route 0 with each pci source; flags read-cleared
    for (j = 0; j < 18; j++) begin
      s = (j < 16) ? j : 0;
      @(posedge clk);
      diag <= (j == 16);
      sockr <= (j == 17);
      wrm(`CSWE_OFS_IRQCFG, {s[3:0], 4'h8});
      pins(want ^ 5'h08);
      chk(isa, (s != 0 && s != 2) ? 16'h0001 << s : 16'h0000);
      chk(smi, s == 2);
      chk(pci, j > 15);
      // a write of one is ignored while reads clear
      wrm(`CSWE_OFS_FLAGS, 8'h08);
      rdm(`CSWE_OFS_FLAGS, 8'h08);
      repeat (3) @(posedge clk);
      #1;
      chk(isa, 16'h0000);
      chk({smi, pci}, 16'h0000);
    end
    // each source masked, then enabled, then write-one cleared
    for (s = 0; s < 4; s++) begin
      @(posedge clk);
      isio <= (s == 0);
      wclr <= 1'b1;
      wrm(`CSWE_OFS_IRQCFG, {4'h3, ~(4'h1 << s)});
      pins(want ^ (5'h01 << s));
      pins(want ^ (5'h01 << s));
      rdm(`CSWE_OFS_FLAGS, 8'h00);
      chk(isa, 16'h0000);
      wrm(`CSWE_OFS_IRQCFG, {4'h3, 4'h1 << s});
      pins(want ^ (5'h01 << s));
      pins(want ^ (5'h01 << s));
      rdm(`CSWE_OFS_FLAGS, 8'h01 << s);
      // in write-one mode a read leaves the flag alone
      rdm(`CSWE_OFS_FLAGS, 8'h01 << s);
      chk(isa, 16'h0008);
      wrm(`CSWE_OFS_FLAGS, 8'h01 << s);
      rdm(`CSWE_OFS_FLAGS, 8'h00);
      chk(isa, 16'h0000);
    end
    // second reset in mid-run, with i/o window 1 still on
    chk({ioon, memon}, 7'h40);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({ioon, memon, pci}, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    rdm(`CSWE_OFS_WINEN, 8'h00);
    rdm(`CSWE_OFS_IRQCFG, 8'h00);
    wrap_up();
  end
  // watchdog at 20000 cycles, far beyond the roughly 700 cycles the tests take
  initial begin
    #800000;
    n_mismatch++;
    wrap_up();
  end
endmodule : test_card_status_irq_and_window_enable
